// File: rtl/rpf_formatter.sv
// Parallel RGB panel output formatter
`timescale 1ns/100ps
module rpf_formatter
    import rpf_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                arst_n_in,
    // Register port
    input  wire logic [ADDR_W-1:0]   reg_addr_in,
    input  wire logic [DATA_W-1:0]   reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic      [DATA_W-1:0]   reg_rdata_out,
    // Pixel source
    input  wire logic [CH_IN_W-1:0]  pix_red_in,
    input  wire logic [CH_IN_W-1:0]  pix_green_in,
    input  wire logic [CH_IN_W-1:0]  pix_blue_in,
    input  wire logic                pix_hsync_in,
    input  wire logic                pix_vsync_in,
    input  wire logic                pix_de_in,
    output logic                     pix_take_out,
    // Panel pins
    output logic                     panel_enable_out,
    output logic                     pclk_out,
    output logic                     vsync_out,
    output logic                     hsync_out,
    output logic                     de_out,
    output logic      [CH_OUT_W-1:0] red_out,
    output logic      [CH_OUT_W-1:0] green_out,
    output logic      [CH_OUT_W-1:0] blue_out
);

    typedef struct packed {
        logic [7:0]          div;
        logic                edge_sel;
        logic                spread;
        logic                dither;
        logic [3*WID_W-1:0]  width;
        logic [3:0]          arrange;
        logic [7:0]          gpo;
        logic [7:0]          cnt;
        logic                raw;
        logic [CH_OUT_W-1:0] s0_r;
        logic [CH_OUT_W-1:0] s0_g;
        logic [CH_OUT_W-1:0] s0_b;
        logic [2:0]          s0_sync;
        logic [CH_OUT_W-1:0] s1_b;
        logic [POS_W-1:0]    col;
        logic [POS_W-1:0]    line;
        logic                de_prev;
        logic [CH_OUT_W-1:0] red;
        logic [CH_OUT_W-1:0] green;
        logic [CH_OUT_W-1:0] blue;
        logic [2:0]          sync;
        logic                pclk;
        logic                take;
        logic [DATA_W-1:0]   rdata;
    } rpf_state_t;

    rpf_state_t          st_q;
    rpf_state_t          st_d;

    logic [7:0]          eff_div;
    logic                running;
    logic                tick;
    logic [1:0]          thresh;
    logic [3*CH_OUT_W-1:0] fmt;
    logic [CH_OUT_W-1:0] log_r;
    logic [CH_OUT_W-1:0] log_g;
    logic [CH_OUT_W-1:0] log_b;
    logic [CH_OUT_W-1:0] ord_r;
    logic [CH_OUT_W-1:0] ord_g;
    logic [CH_OUT_W-1:0] ord_b;
    logic [CH_OUT_W-1:0] pin_r;
    logic [CH_OUT_W-1:0] pin_g;
    logic [CH_OUT_W-1:0] pin_b;

    function automatic logic [CH_OUT_W-1:0] rev6(
        input logic [CH_OUT_W-1:0] x
    );
        return {<<{x}};
    endfunction : rev6

    // Bayer order 0,3 / 2,1 across column and line
    assign thresh = {st_q.col[0] ^ st_q.line[0], st_q.col[0]};

    rpf_dither #(
        .NCH          (3)
    ) u_dither (
        .pix_in       ({pix_red_in, pix_green_in, pix_blue_in}),
        .width_in     (st_q.width),
        .thresh_in    (thresh),
        .dither_en_in (st_q.dither),
        .pix_out      (fmt)
    );

    assign log_r = fmt[2*CH_OUT_W +: CH_OUT_W];
    assign log_g = fmt[CH_OUT_W +: CH_OUT_W];
    assign log_b = fmt[0 +: CH_OUT_W];

    // Channel order onto the pin groups
    always_comb begin
        casez (st_q.arrange[ARR_ROTATE:ARR_SWAP])
            3'b0?0: begin
                ord_r = log_r;
                ord_g = log_g;
                ord_b = log_b;
            end
            3'b0?1: begin
                ord_r = log_b;
                ord_g = log_g;
                ord_b = log_r;
            end
            3'b100: begin
                ord_r = log_g;
                ord_g = log_b;
                ord_b = log_r;
            end
            3'b101: begin
                ord_r = log_g;
                ord_g = log_r;
                ord_b = log_b;
            end
            3'b110: begin
                ord_r = log_b;
                ord_g = log_r;
                ord_b = log_g;
            end
            default: begin
                ord_r = log_r;
                ord_g = log_b;
                ord_b = log_g;
            end
        endcase
    end

    assign pin_r = st_q.arrange[ARR_REVERSE] ? rev6(ord_r) : ord_r;
    assign pin_g = st_q.arrange[ARR_REVERSE] ? rev6(ord_g) : ord_g;
    assign pin_b = st_q.arrange[ARR_REVERSE] ? rev6(ord_b) : ord_b;

    // Divisor of one behaves as two; zero stops the pixel clock
    assign eff_div = (st_q.div < MIN_DIV) ? MIN_DIV : st_q.div;
    assign running = (st_q.div != 8'h00);
    assign tick    = running && (st_q.cnt >= eff_div - 8'h01);

    always_comb begin
        st_d = st_q;
        // Pixel clock divider
        if (running) begin
            st_d.cnt = tick ? 8'h00 : st_q.cnt + 8'h01;
        end else begin
            st_d.cnt = 8'h00;
        end
        st_d.raw  = running && (st_d.cnt < (eff_div >> 1));
        st_d.pclk = running && (st_d.raw ^ st_q.edge_sel);
        st_d.take = tick;

        // Pixel pipeline, advanced on the active edge
        if (tick) begin
            st_d.s0_r    = pin_r;
            st_d.s0_g    = pin_g;
            st_d.s0_b    = pin_b;
            st_d.s0_sync = {pix_vsync_in, pix_hsync_in, pix_de_in};
            st_d.s1_b    = st_q.s0_b;
            st_d.green   = st_q.s0_g;
            st_d.sync    = st_q.s0_sync;
            if (st_q.spread) begin
                st_d.red  = pin_r;
                st_d.blue = st_q.s1_b;
            end else begin
                st_d.red  = st_q.s0_r;
                st_d.blue = st_q.s0_b;
            end
            // Position counters for the dither matrix
            st_d.col = pix_de_in ? st_q.col + 9'h001 : 9'h000;
            if (pix_vsync_in) begin
                st_d.line = 9'h000;
            end else if (st_q.de_prev && !pix_de_in) begin
                st_d.line = st_q.line + 9'h001;
            end
            st_d.de_prev = pix_de_in;
        end

        // Register writes
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                OFS_PCLK_DIV:  st_d.div      = reg_wdata_in[7:0];
                OFS_EDGE_SEL:  st_d.edge_sel = reg_wdata_in[0];
                OFS_SPREAD:    st_d.spread   = reg_wdata_in[0];
                OFS_DITHER:    st_d.dither   = reg_wdata_in[0];
                OFS_OUT_WIDTH: st_d.width    = reg_wdata_in[8:0];
                OFS_ARRANGE:   st_d.arrange  = reg_wdata_in[3:0];
                OFS_GPO:       st_d.gpo      = reg_wdata_in[7:0];
                default: ;
            endcase
        end

        // Register reads, data valid for one cycle
        st_d.rdata = '0;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_PCLK_DIV:  st_d.rdata = {24'h0, st_q.div};
                OFS_EDGE_SEL:  st_d.rdata = {31'h0, st_q.edge_sel};
                OFS_SPREAD:    st_d.rdata = {31'h0, st_q.spread};
                OFS_DITHER:    st_d.rdata = {31'h0, st_q.dither};
                OFS_OUT_WIDTH: st_d.rdata = {23'h0, st_q.width};
                OFS_ARRANGE:   st_d.rdata = {28'h0, st_q.arrange};
                OFS_GPO:       st_d.rdata = {24'h0, st_q.gpo};
                OFS_STATUS:    st_d.rdata = {13'h0, st_q.line,
                                             st_q.col, running};
                default:       st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_q          <= '0;
            st_q.div      <= RST_PCLK_DIV;
            st_q.edge_sel <= RST_EDGE_SEL;
            st_q.spread   <= RST_SPREAD;
            st_q.dither   <= RST_DITHER;
            st_q.width    <= {RST_CH_WIDTH, RST_CH_WIDTH, RST_CH_WIDTH};
            st_q.arrange  <= RST_ARRANGE;
            st_q.gpo      <= RST_GPO;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_out    = st_q.rdata;
    assign pix_take_out     = st_q.take;
    assign panel_enable_out = st_q.gpo[GPO_PANEL_EN];
    assign pclk_out         = st_q.pclk;
    assign vsync_out        = st_q.sync[2];
    assign hsync_out        = st_q.sync[1];
    assign de_out           = st_q.sync[0];
    assign red_out          = st_q.red;
    assign green_out        = st_q.green;
    assign blue_out         = st_q.blue;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    a_pclk_off_low: assert property (
        !running |=> !pclk_out && !pix_take_out
    ) else $error("pixel clock active with zero divisor");

    a_tick_period: assert property (
        (tick && st_q.div == 8'h03 && $past(st_q.div, 3) == 8'h03)
        |-> $past(tick, 3) && !$past(tick, 1) && !$past(tick, 2)
    ) else $error("pixel period differs from divisor");

    a_active_level: assert property (
        tick |=> pclk_out == !st_q.edge_sel
    ) else $error("pixel clock level wrong after active edge");

    a_green_moves: assert property (
        $changed(green_out) |-> $past(tick)
    ) else $error("green changed away from active edge");

    a_spread_off: assert property (
        (tick && !st_q.spread) |=> red_out == $past(st_q.s0_r)
            && blue_out == $past(st_q.s0_b)
            && green_out == $past(st_q.s0_g)
    ) else $error("colours not updated together");

    a_spread_on: assert property (
        (tick && st_q.spread) |=> red_out == $past(pin_r)
            && blue_out == $past(st_q.s1_b)
    ) else $error("spread timing of red or blue wrong");

    a_dither_none: assert property (
        (!st_q.dither && st_q.width == 9'h1b6)
            |-> log_g == pix_green_in[7:2]
    ) else $error("undithered green not truncated");

    a_dither_step: assert property (
        (st_q.dither && st_q.width == 9'h1b6 && thresh == 2'b11
            && pix_green_in[1:0] != 2'b00 && pix_green_in[7:2] != 6'h3f)
            |-> log_g == pix_green_in[7:2] + 6'h01
    ) else $error("dither did not carry the low bits");

    a_low_pins_zero: assert property (
        st_q.width[WID_RED_POS +: WID_W] == 3'h2 |-> log_r[3:0] == 4'h0
    ) else $error("unused red pins not zero");

    a_reverse_bits: assert property (
        st_q.arrange == 4'b0001 |-> pin_r == rev6(log_r)
    ) else $error("bit reversal wrong");

    a_swap_rb: assert property (
        st_q.arrange == 4'b0010 |-> pin_r == log_b && pin_b == log_r
            && pin_g == log_g
    ) else $error("red and blue swap wrong");

    a_rotate_dir: assert property (
        st_q.arrange[3] && !st_q.arrange[1] && !st_q.arrange[0]
            |-> (st_q.arrange[2] ? pin_r == log_b : pin_r == log_g)
    ) else $error("rotation direction wrong");

    a_panel_write: assert property (
        (reg_wr_in && reg_addr_in == OFS_GPO)
            |=> panel_enable_out == $past(reg_wdata_in[GPO_PANEL_EN])
    ) else $error("panel enable did not follow write");

    a_col_count: assert property (
        (tick && pix_de_in) |=> st_q.col == $past(st_q.col) + 9'h001
    ) else $error("column counter did not advance");

endmodule : rpf_formatter

// File: rtl/rpf_pkg.sv
// Constants shared by the panel output formatter
package rpf_pkg;

    // Register port geometry
    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned DATA_W      = 32;

    // Register offsets
    localparam logic [3:0]  OFS_PCLK_DIV  = 4'h0;
    localparam logic [3:0]  OFS_EDGE_SEL  = 4'h1;
    localparam logic [3:0]  OFS_SPREAD    = 4'h2;
    localparam logic [3:0]  OFS_DITHER    = 4'h3;
    localparam logic [3:0]  OFS_OUT_WIDTH = 4'h4;
    localparam logic [3:0]  OFS_ARRANGE   = 4'h5;
    localparam logic [3:0]  OFS_GPO       = 4'h6;
    localparam logic [3:0]  OFS_STATUS    = 4'h7;

    // Reset values
    localparam logic [7:0]  RST_PCLK_DIV  = 8'h00;
    localparam logic        RST_EDGE_SEL  = 1'b0;
    localparam logic        RST_SPREAD    = 1'b0;
    localparam logic        RST_DITHER    = 1'b1;
    localparam logic [2:0]  RST_CH_WIDTH  = 3'h6;
    localparam logic [3:0]  RST_ARRANGE   = 4'h0;
    localparam logic [7:0]  RST_GPO       = 8'h00;

    // Field positions
    localparam int unsigned ARR_REVERSE   = 0;
    localparam int unsigned ARR_SWAP      = 1;
    localparam int unsigned ARR_RIGHT     = 2;
    localparam int unsigned ARR_ROTATE    = 3;
    localparam int unsigned GPO_PANEL_EN  = 7;
    localparam int unsigned WID_RED_POS   = 6;
    localparam int unsigned WID_GREEN_POS = 3;
    localparam int unsigned WID_BLUE_POS  = 0;

    // Data widths and divider limits
    localparam int unsigned CH_IN_W       = 8;
    localparam int unsigned CH_OUT_W      = 6;
    localparam int unsigned WID_W         = 3;
    localparam int unsigned POS_W         = 9;
    localparam logic [7:0]  MIN_DIV       = 8'h02;

endpackage : rpf_pkg

// File: rtl/rpf_dither.sv
// Per-channel 2x2 dither, width reduction and low-pin masking
`timescale 1ns/100ps
module rpf_dither
    import rpf_pkg::*;
#(
    parameter int unsigned NCH = 3
) (
    // Colour in
    input  wire logic [NCH*CH_IN_W-1:0]  pix_in,
    input  wire logic [NCH*WID_W-1:0]    width_in,
    input  wire logic [1:0]              thresh_in,
    input  wire logic                    dither_en_in,
    // Colour out, left aligned
    output logic      [NCH*CH_OUT_W-1:0] pix_out
);

    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        logic [CH_IN_W-1:0]  val;
        logic [WID_W-1:0]    wid;
        logic [3:0]          drop;
        logic [11:0]         wide;
        logic [9:0]          sum;
        logic [CH_IN_W-1:0]  sat;
        logic [CH_OUT_W-1:0] mask;

        assign val  = pix_in[ch*CH_IN_W +: CH_IN_W];
        // Widths above six clamp to six
        assign wid  = (width_in[ch*WID_W +: WID_W] > 3'h6) ? 3'h6
                    : width_in[ch*WID_W +: WID_W];
        assign drop = 4'h8 - {1'b0, wid};
        // Threshold scaled to a quarter step of the kept LSB
        assign wide = {10'h000, thresh_in} << drop;
        assign sum  = {2'b00, val}
                    + (dither_en_in ? wide[11:2] : 10'h000);
        assign sat  = (sum > 10'h0ff) ? 8'hff : sum[7:0];
        assign mask = ~(6'h3f >> wid);
        assign pix_out[ch*CH_OUT_W +: CH_OUT_W] = sat[7:2] & mask;
    end

endmodule : rpf_dither

// File: tb/rpf_panel_model.sv
// Panel model: spots active pixel clock edges and pin movement
`timescale 1ns/100ps
module rpf_panel_model (
    // Observed panel pins
    input  wire logic        clk_in,
    input  wire logic        pclk_in,
    input  wire logic        fall_in,
    input  wire logic        watch_in,
    input  wire logic [17:0] data_in,
    // What the panel saw
    output logic             edge_out,
    output logic      [7:0]  period_out,
    output int               glitch_out
);
    logic        act_q    = 1'b0;
    logic [17:0] data_q;
    logic [7:0]  cnt_q    = 8'h00;
    int          glitch_q = 0;

    assign edge_out   = (pclk_in ^ fall_in) & ~act_q;
    assign glitch_out = glitch_q;

    always @(posedge clk_in) begin
        act_q  <= pclk_in ^ fall_in;
        data_q <= data_in;
        cnt_q  <= edge_out ? 8'h01 : cnt_q + 8'h01;
        if (edge_out)
            period_out <= cnt_q;
        // Data may only move in the cycle of an active edge
        if (watch_in && !edge_out && data_in !== data_q)
            glitch_q <= glitch_q + 1;
    end
endmodule : rpf_panel_model

// File: tb/test_rpf_formatter.sv
// Self-checking bench for the panel output formatter
`timescale 1ns/100ps
module test_rpf_formatter;
    import rpf_pkg::*;

    logic        clk_in       = 1'b0;
    logic        arst_n_in    = 1'b0;
    logic [3:0]  reg_addr_in  = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        reg_wr_in    = 1'b0;
    logic        reg_rd_in    = 1'b0;
    logic [7:0]  pix_red_in   = 8'h00;
    logic [7:0]  pix_green_in = 8'h00;
    logic [7:0]  pix_blue_in  = 8'h00;
    logic        pix_hsync_in = 1'b0;
    logic        pix_vsync_in = 1'b0;
    logic        pix_de_in    = 1'b0;
    logic        watch        = 1'b0;
    int          errors       = 0;
    int          comparisons  = 0;
    logic [31:0] reg_rdata_out, d;
    logic        pix_take_out, panel_enable_out, pclk_out, pedge;
    logic        vsync_out, hsync_out, de_out, esel, spr;
    logic [5:0]  red_out, green_out, blue_out;
    logic [7:0]  period, div;
    logic [8:0]  wid;
    logic [3:0]  arr;
    int          glitch;
    logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1b6, 32'h0,
                            32'h0, 32'h0};
    logic [31:0] wv [7] = '{32'ha5, 32'h1, 32'h1, 32'h0, 32'h0d1, 32'ha,
                            32'h80};

    always #4 clk_in = ~clk_in;

    rpf_formatter u_rpf_formatter (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .pix_red_in(pix_red_in), .pix_green_in(pix_green_in),
        .pix_blue_in(pix_blue_in), .pix_hsync_in(pix_hsync_in),
        .pix_vsync_in(pix_vsync_in), .pix_de_in(pix_de_in),
        .pix_take_out(pix_take_out), .panel_enable_out(panel_enable_out),
        .pclk_out(pclk_out), .vsync_out(vsync_out), .hsync_out(hsync_out),
        .de_out(de_out), .red_out(red_out), .green_out(green_out),
        .blue_out(blue_out));

    rpf_panel_model u_rpf_panel_model (
        .clk_in(clk_in), .pclk_in(pclk_out), .fall_in(esel),
        .watch_in(watch), .data_in({red_out, green_out, blue_out}),
        .edge_out(pedge), .period_out(period), .glitch_out(glitch));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        #1 v = reg_rdata_out;
    endtask : rd

    function automatic logic [5:0] chan(input logic [7:0] v,
                                        input logic [2:0] w);
        return v[7:2] & ~(6'h3f >> ((w > 3'd6) ? 3'd6 : w));
    endfunction : chan

    // Weight of one kept LSB on a six-bit pin group
    function automatic logic [5:0] lsb(input logic [2:0] w);
        return 6'h20 >> (w - 3'd1);
    endfunction : lsb

    function automatic logic [5:0] rev(input logic [5:0] x);
        return {x[0], x[1], x[2], x[3], x[4], x[5]};
    endfunction : rev

    function automatic logic [17:0] pins(input logic [5:0] r, g, b,
                                         input logic [3:0] a);
        logic [17:0] p;
        case (a[3:1])
            3'h1, 3'h3: p = {b, g, r};
            3'h4:       p = {g, b, r};
            3'h5:       p = {g, r, b};
            3'h6:       p = {b, r, g};
            3'h7:       p = {r, b, g};
            default:    p = {r, g, b};
        endcase
        if (a[0])
            p = {rev(p[17:12]), rev(p[11:6]), rev(p[5:0])};
        return p;
    endfunction : pins

    task automatic cfg(input logic [7:0] dv, input logic es, sp, dt,
                       input logic [8:0] w, input logic [3:0] a);
        div  = dv;
        esel = es;
        spr  = sp;
        wid  = w;
        arr  = a;
        wr(OFS_PCLK_DIV, 32'h0);
        wr(OFS_EDGE_SEL, {31'h0, es});
        wr(OFS_SPREAD, {31'h0, sp});
        wr(OFS_DITHER, {31'h0, dt});
        wr(OFS_OUT_WIDTH, {23'h0, w});
        wr(OFS_ARRANGE, {28'h0, a});
        wr(OFS_PCLK_DIV, {24'h0, dv});
    endtask : cfg

    // Pins in the take cycle show the previous pixel; spread moves R and B
    task automatic stream(input int n, input bit dz);
        logic [26:0] cur, h0, h1;
        logic [17:0] seen, exp, e0, e1, lastp;
        int          k, t, incs;
        k = 0;
        t = 0;
        incs = 0;
        e0 = pins(chan(8'h8a, wid[8:6]), chan(8'h8a, wid[5:3]),
                  chan(8'h8a, wid[2:0]), 4'h0);
        e1 = e0 + {lsb(wid[8:6]), lsb(wid[5:3]), lsb(wid[2:0])};
        while (k < n && t < 4000) begin
            @(posedge clk_in);
            t++;
            if (pix_take_out === 1'b1) begin
                cur  = {pix_red_in, pix_green_in, pix_blue_in,
                        pix_hsync_in, pix_vsync_in, pix_de_in};
                seen = {red_out, green_out, blue_out};
                exp  = pins(chan(spr ? cur[26:19] : h0[26:19], wid[8:6]),
                            chan(h0[18:11], wid[5:3]),
                            chan(spr ? h1[10:3] : h0[10:3], wid[2:0]), arr);
                if (k >= 3) begin
                    watch <= 1'b1;
                    check(pedge, 1'b1);
                    check(period, (div < MIN_DIV) ? MIN_DIV : div);
                end
                if (k >= 3 && dz) begin
                    check(seen === e0 || seen === e1, 1'b1);
                    check(seen !== lastp, 1'b1);
                    incs += int'(seen === e1);
                end
                if (k >= 3 && !dz) begin
                    check(seen, exp);
                    check({hsync_out, vsync_out, de_out}, h0[2:0]);
                end
                lastp = seen;
                h1 = h0;
                h0 = cur;
                k++;
                // Last pixel stays on the inputs for the next scenario
                if (!dz && k < n)
                    {pix_red_in, pix_green_in, pix_blue_in, pix_hsync_in,
                     pix_vsync_in, pix_de_in} <= 27'($urandom);
            end
        end
        @(posedge clk_in);
        watch <= 1'b0;
        check(k, n);
        if (dz)
            check(incs > 0, 1'b1);
    endtask : stream

    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        #300us;
        errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(52096));
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            rd(4'(i), d);
            check(d, i < 8 ? rv[i] : 32'h0);
        end
        repeat (20) begin
            @(posedge clk_in);
            check({pclk_out, pix_take_out}, 2'b00);
        end
        for (int i = 0; i < 7; i++) begin
            wr(4'(i), wv[i]);
            rd(4'(i), d);
            check(d, wv[i]);
        end
        wr(4'h9, 32'hffff_ffff);
        rd(4'h9, d);
        check(d, 32'h0);
        for (int i = 0; i < 4; i++) begin
            d = {24'h0, i[0], 7'($urandom)};
            wr(OFS_GPO, d);
            repeat (2) @(posedge clk_in);
            check(panel_enable_out, d[7]);
        end
        // Every arrangement code, then spread, random widths and alternating edges
        for (int r = 0; r < 18; r++) begin
            cfg(8'(1 + $urandom_range(4)), r[0], r >= 16, 1'b0,
                r == 0 ? 9'h1b6 : 9'($urandom), 4'(r));
            stream(24, 1'b0);
        end
        {pix_red_in, pix_green_in, pix_blue_in} <= {3{8'h8a}};
        // Vertical sync held high keeps the line count even
        {pix_hsync_in, pix_vsync_in, pix_de_in} <= 3'b011;
        for (int w = 0; w < 2; w++) begin
            cfg(8'h03, 1'b0, 1'b0, 1'b1, w[0] ? 9'h1b6 : 9'h1a6, 4'h0);
            stream(24, 1'b1);
        end
        check(glitch, 0);
        print_verdict();
    end
endmodule : test_rpf_formatter
